// [logic/mpw_defines.svh]
/*
  Offsets, field positions, reset values and fault codes for the page walk and fault check block.
  Assumes inclusion by bare name from the top module.
*/
`ifndef MPW_DEFINES_SVH
`define MPW_DEFINES_SVH

// register byte offsets on the register bus
`define MPW_OFF_CTRL        8'h00
`define MPW_OFF_TBASE       8'h04
`define MPW_OFF_DOMAIN      8'h08
`define MPW_OFF_FSTAT       8'h0c
`define MPW_OFF_FADDR       8'h10

// control register bit positions
`define MPW_CTRL_MMU_EN     0
`define MPW_CTRL_ALIGN_EN   1
`define MPW_CTRL_CACHE_EN   2
`define MPW_CTRL_WBUF_EN    3
`define MPW_CTRL_SYS_PROT   8
`define MPW_CTRL_ROM_PROT   9
`define MPW_CTRL_MASK       32'h0000030f

// reset values
`define MPW_CTRL_RESET      32'h00000000
`define MPW_TBASE_RESET     32'h00000000
`define MPW_DOMAIN_RESET    32'h00000000
`define MPW_TBASE_MASK      32'hffffc000

// descriptor and entry fields
`define MPW_BUF_BIT         2
`define MPW_CACHE_BIT       3
`define MPW_SUBPERM_LSB     4
`define MPW_SECT_AP_LSB     10

// descriptor type codes
`define MPW_TYPE_FAULT      2'b00
`define MPW_TYPE_L1_PAGE    2'b01
`define MPW_TYPE_L1_SECT    2'b10
`define MPW_TYPE_LARGE      2'b01
`define MPW_TYPE_SMALL      2'b10

// domain field codes
`define MPW_DOM_NONE        2'b00
`define MPW_DOM_CLIENT      2'b01
`define MPW_DOM_RSVD        2'b10
`define MPW_DOM_MANAGER     2'b11

// fault codes, highest priority first
`define MPW_FC_NONE         4'h0
`define MPW_FC_ALIGN        4'h1
`define MPW_FC_SECT_TRANS   4'h5
`define MPW_FC_PAGE_TRANS   4'h7
`define MPW_FC_SECT_DOM     4'h9
`define MPW_FC_PAGE_DOM     4'hb
`define MPW_FC_SECT_PERM    4'hd
`define MPW_FC_PAGE_PERM    4'hf

// bus responses
`define MPW_RESP_OKAY       2'b00
`define MPW_RESP_SLVERR     2'b10

`endif

// [logic/mpw_pkg.sv]
/*
  Types for the page walk and fault check block.
  Assumes the defines header is compiled alongside.
*/
package mpw_pkg;
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_CHECK,
        ST_L1,
        ST_L2,
        ST_JUDGE
    } mpw_state_t;
endpackage

// [logic/mpw_top.sv]
/*
  Page table walk and access fault check with an AXI4-Lite register slave.
  Assumes a core that holds its request until done, and a table memory that
  answers each read with a one-cycle acknowledge.
*/
// Chosen here: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "mpw_defines.svh"

module mpw_top (
    // clock and reset
    input  wire logic        CORE_CLK,
    input  wire logic        RSTN,
    // register bus
    input  wire logic [7:0]  AWADDR,
    input  wire logic        AWVALID,
    output logic             AWREADY,
    input  wire logic [31:0] WDATA,
    input  wire logic [3:0]  WSTRB,
    input  wire logic        WVALID,
    output logic             WREADY,
    output logic [1:0]       BRESP,
    output logic             BVALID,
    input  wire logic        BREADY,
    input  wire logic [7:0]  ARADDR,
    input  wire logic        ARVALID,
    output logic             ARREADY,
    output logic [31:0]      RDATA,
    output logic [1:0]       RRESP,
    output logic             RVALID,
    input  wire logic        RREADY,
    // core access request
    input  wire logic        CORE_REQ,
    input  wire logic [31:0] CORE_VADDR,
    input  wire logic        CORE_WRITE,
    input  wire logic        CORE_WORD,
    input  wire logic        CORE_DATA,
    input  wire logic        CORE_USER,
    // core answer
    output logic             CORE_DONE,
    output logic             CORE_ABORT,
    output logic             CORE_FETCH_ABORT,
    output logic [31:0]      CORE_PADDR,
    // table memory reads
    output logic             MEM_REQ,
    output logic [31:0]      MEM_ADDR,
    input  wire logic [31:0] MEM_RDATA,
    input  wire logic        MEM_ACK,
    // external access launch
    output logic             EXT_REQ,
    output logic [31:0]      EXT_ADDR,
    output logic             EXT_WRITE,
    output logic             EXT_CACHEABLE,
    output logic             EXT_BUFFERABLE
);
    localparam int TLB_N = 4;

    logic [1:0]         rst_sync_reg;
    logic               rst_n;
    mpw_pkg::mpw_state_t state_reg;

    // registers
    logic [31:0] ctrl_reg;
    logic [31:0] tbase_reg;
    logic [31:0] domain_rights_reg;
    logic [7:0]  fault_status_reg;
    logic [31:0] fault_address_reg;

    // bus slave state
    logic        aw_full_reg;
    logic        w_full_reg;
    logic [7:0]  aw_addr_reg;
    logic [31:0] w_data_reg;
    logic [3:0]  w_strb_reg;

    // current access
    logic [31:0] va_reg;
    logic        wr_reg;
    logic        word_reg;
    logic        data_reg;
    logic        user_reg;
    logic [31:0] l1_reg;
    logic [31:0] l2_reg;

    // translation buffer
    logic [19:0] tlb_tag [TLB_N];
    logic [31:0] tlb_l1  [TLB_N];
    logic [31:0] tlb_l2  [TLB_N];
    logic [TLB_N-1:0] tlb_vld_reg;
    logic [1:0]  tlb_ptr_reg;

    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            rst_sync_reg <= 2'h0;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_reg[1];

    // permission field judgement, shared by sections and sub-pages
    function automatic logic ap_allows(input logic [1:0] ap, input logic sp, input logic rp,
                                       input logic user, input logic wr);
        logic ok;
        ok = 1'b0;
        case (ap)
            2'b00: ok = (sp && !rp) ? (!user && !wr) : ((!sp && rp) ? !wr : 1'b0);
            2'b01: ok = !user;
            2'b10: ok = !user || !wr;
            2'b11: ok = 1'b1;
            default: ok = 1'b0;
        endcase
        return ok;
    endfunction

    // bus decode
    wire        wr_go     = aw_full_reg && w_full_reg && !BVALID;
    wire        wr_ctrl   = wr_go && (aw_addr_reg == `MPW_OFF_CTRL);
    wire        wr_tbase  = wr_go && (aw_addr_reg == `MPW_OFF_TBASE);
    wire        wr_domain = wr_go && (aw_addr_reg == `MPW_OFF_DOMAIN);
    wire        wr_fstat  = wr_go && (aw_addr_reg == `MPW_OFF_FSTAT);
    wire        wr_faddr  = wr_go && (aw_addr_reg == `MPW_OFF_FADDR);
    wire        wr_mapped = wr_ctrl || wr_tbase || wr_domain || wr_fstat || wr_faddr;
    wire [31:0] wmask     = {{8{w_strb_reg[3]}}, {8{w_strb_reg[2]}}, {8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};
    wire        rd_take   = ARVALID && ARREADY;
    wire        rd_mapped = (ARADDR == `MPW_OFF_CTRL) || (ARADDR == `MPW_OFF_TBASE) ||
                            (ARADDR == `MPW_OFF_DOMAIN) || (ARADDR == `MPW_OFF_FSTAT) ||
                            (ARADDR == `MPW_OFF_FADDR);
    wire [31:0] rd_value  = (ARADDR == `MPW_OFF_CTRL)   ? ctrl_reg :
                            (ARADDR == `MPW_OFF_TBASE)  ? tbase_reg :
                            (ARADDR == `MPW_OFF_DOMAIN) ? domain_rights_reg :
                            (ARADDR == `MPW_OFF_FSTAT)  ? {24'h0, fault_status_reg} :
                            (ARADDR == `MPW_OFF_FADDR)  ? fault_address_reg : 32'h0;

    // control fields
    wire mmu_en   = ctrl_reg[`MPW_CTRL_MMU_EN];
    wire align_en = ctrl_reg[`MPW_CTRL_ALIGN_EN];
    wire sys_prot = ctrl_reg[`MPW_CTRL_SYS_PROT];
    wire rom_prot = ctrl_reg[`MPW_CTRL_ROM_PROT];

    // translation buffer lookup
    logic [TLB_N-1:0] hit_vec;
    logic [31:0]      hit_l1;
    logic [31:0]      hit_l2;
    genvar gi;
    generate
        for (gi = 0; gi < TLB_N; gi++) begin : g_hit
            assign hit_vec[gi] = tlb_vld_reg[gi] && (tlb_tag[gi] == va_reg[31:12]);
        end
    endgenerate
    always_comb begin
        hit_l1 = 32'h0;
        hit_l2 = 32'h0;
        for (int i = 0; i < TLB_N; i++) begin
            if (hit_vec[i]) begin
                hit_l1 = tlb_l1[i];
                hit_l2 = tlb_l2[i];
            end
        end
    end
    wire tlb_hit = |hit_vec;

    wire align_flt = align_en && data_reg && word_reg && (va_reg[1:0] != 2'b00);

    wire [31:0] l1_addr = {tbase_reg[31:14], va_reg[31:20], 2'b00};
    // second-level entry address from the first-level page table descriptor
    wire [31:0] l2_addr = {MEM_RDATA[31:10], va_reg[19:12], 2'b00};

    wire l1_sect    = (MEM_RDATA[1:0] == `MPW_TYPE_L1_SECT);
    wire l1_page    = (MEM_RDATA[1:0] == `MPW_TYPE_L1_PAGE);
    wire l2_valid   = (MEM_RDATA[1:0] == `MPW_TYPE_LARGE) || (MEM_RDATA[1:0] == `MPW_TYPE_SMALL);

    // judged descriptors
    wire        is_sect   = (l1_reg[1:0] == `MPW_TYPE_L1_SECT);
    wire        is_large  = (l2_reg[1:0] == `MPW_TYPE_LARGE);
    wire        pg_trans  = !is_sect && !((l2_reg[1:0] == `MPW_TYPE_LARGE) || (l2_reg[1:0] == `MPW_TYPE_SMALL));
    // domain index from first level, domain 0 lowest
    wire [3:0]  dom_idx   = l1_reg[8:5];
    wire [1:0]  dom_field = domain_rights_reg[{dom_idx, 1'b0} +: 2];
    wire [1:0]  quarter   = is_large ? va_reg[15:14] : va_reg[11:10];
    wire [1:0]  sub_ap    = l2_reg[`MPW_SUBPERM_LSB + {quarter, 1'b0} +: 2];
    wire [1:0]  sect_ap   = l1_reg[`MPW_SECT_AP_LSB +: 2];
    // section judged with system protect, sub-page judged alike, decode
    wire        perm_ok   = ap_allows(is_sect ? sect_ap : sub_ap, sys_prot, rom_prot, user_reg, wr_reg);
    // domain 00 and 10 refuse every access
    wire        dom_flt   = (dom_field == `MPW_DOM_NONE) || (dom_field == `MPW_DOM_RSVD);
    // permission only checked for client domains
    wire        perm_flt  = (dom_field == `MPW_DOM_CLIENT) && !perm_ok;
    wire [3:0]  judge_code = pg_trans ? `MPW_FC_PAGE_TRANS :
                             dom_flt  ? (is_sect ? `MPW_FC_SECT_DOM : `MPW_FC_PAGE_DOM) :
                             perm_flt ? (is_sect ? `MPW_FC_SECT_PERM : `MPW_FC_PAGE_PERM) :
                             `MPW_FC_NONE;
    wire [31:0] judge_pa  = is_sect  ? {l1_reg[31:20], va_reg[19:0]} :
                            is_large ? {l2_reg[31:16], va_reg[15:0]} :
                                       {l2_reg[31:12], va_reg[11:0]};
    // cache and buffer attributes gated by their enables
    wire [31:0] attr_src  = is_sect ? l1_reg : l2_reg;
    wire        judge_c   = attr_src[`MPW_CACHE_BIT] && ctrl_reg[`MPW_CTRL_CACHE_EN];
    wire        judge_b   = attr_src[`MPW_BUF_BIT] && ctrl_reg[`MPW_CTRL_WBUF_EN];

    // finish decision for this cycle
    logic        fin;
    logic [3:0]  fin_code;
    logic [3:0]  fin_dom;
    logic [31:0] fin_pa;
    logic        fin_c;
    logic        fin_b;
    always_comb begin
        fin      = 1'b0;
        fin_code = `MPW_FC_NONE;
        fin_dom  = 4'h0;
        fin_pa   = va_reg;
        fin_c    = 1'b0;
        fin_b    = 1'b0;
        case (state_reg)
            mpw_pkg::ST_CHECK: begin
                if (align_flt) begin
                    fin      = 1'b1;
                    fin_code = `MPW_FC_ALIGN;
                end else if (!mmu_en) begin
                    fin = 1'b1;
                end
            end
            mpw_pkg::ST_L1: begin
                // domain taken from the invalid descriptor
                if (MEM_ACK && !l1_sect && !l1_page) begin
                    fin      = 1'b1;
                    fin_code = `MPW_FC_SECT_TRANS;
                    fin_dom  = MEM_RDATA[8:5];
                end
            end
            mpw_pkg::ST_JUDGE: begin
                fin      = 1'b1;
                fin_code = judge_code;
                fin_dom  = dom_idx;
                fin_pa   = judge_pa;
                fin_c    = judge_c;
                fin_b    = judge_b;
            end
            default: fin = 1'b0;
        endcase
    end
    wire fault = (fin_code != `MPW_FC_NONE);

    // bus slave
    always_ff @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            AWREADY     <= 1'b0;
            WREADY      <= 1'b0;
            BVALID      <= 1'b0;
            BRESP       <= `MPW_RESP_OKAY;
            ARREADY     <= 1'b0;
            RVALID      <= 1'b0;
            RDATA       <= 32'h0;
            RRESP       <= `MPW_RESP_OKAY;
            aw_full_reg <= 1'b0;
            w_full_reg  <= 1'b0;
            aw_addr_reg <= 8'h0;
            w_data_reg  <= 32'h0;
            w_strb_reg  <= 4'h0;
        end else begin
            AWREADY <= !aw_full_reg && !(AWVALID && AWREADY);
            WREADY  <= !w_full_reg && !(WVALID && WREADY);
            if (AWVALID && AWREADY) begin
                aw_full_reg <= 1'b1;
                aw_addr_reg <= {AWADDR[7:2], 2'b00};
            end
            if (WVALID && WREADY) begin
                w_full_reg <= 1'b1;
                w_data_reg <= WDATA;
                w_strb_reg <= WSTRB;
            end
            if (wr_go) begin
                BVALID <= 1'b1;
                BRESP  <= wr_mapped ? `MPW_RESP_OKAY : `MPW_RESP_SLVERR;
            end
            if (BVALID && BREADY) begin
                BVALID      <= 1'b0;
                aw_full_reg <= 1'b0;
                w_full_reg  <= 1'b0;
            end
            ARREADY <= !RVALID && !rd_take;
            if (rd_take) begin
                RVALID <= 1'b1;
                RDATA  <= rd_value;
                RRESP  <= rd_mapped ? `MPW_RESP_OKAY : `MPW_RESP_SLVERR;
            end else if (RVALID && RREADY) begin
                RVALID <= 1'b0;
            end
        end
    end

    // software registers and fault capture
    always_ff @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_reg          <= `MPW_CTRL_RESET;
            tbase_reg         <= `MPW_TBASE_RESET;
            domain_rights_reg <= `MPW_DOMAIN_RESET;
            fault_status_reg  <= 8'h0;
            fault_address_reg <= 32'h0;
        end else begin
            if (wr_ctrl) begin
                ctrl_reg <= ((ctrl_reg & ~wmask) | (w_data_reg & wmask)) & `MPW_CTRL_MASK;
            end
            if (wr_tbase) begin
                tbase_reg <= ((tbase_reg & ~wmask) | (w_data_reg & wmask)) & `MPW_TBASE_MASK;
            end
            if (wr_domain) begin
                domain_rights_reg <= (domain_rights_reg & ~wmask) | (w_data_reg & wmask);
            end
            // data abort capture; bus writes never load fault_status_reg or fault_address_reg
            if (fin && fault && data_reg) begin
                fault_status_reg  <= {fin_dom, fin_code};
                fault_address_reg <= va_reg;
            end
        end
    end

    // walk and check sequencer
    always_ff @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            state_reg        <= mpw_pkg::ST_IDLE;
            va_reg           <= 32'h0;
            wr_reg           <= 1'b0;
            word_reg         <= 1'b0;
            data_reg         <= 1'b0;
            user_reg         <= 1'b0;
            l1_reg           <= 32'h0;
            l2_reg           <= 32'h0;
            MEM_REQ          <= 1'b0;
            MEM_ADDR         <= 32'h0;
            CORE_DONE        <= 1'b0;
            CORE_ABORT       <= 1'b0;
            CORE_FETCH_ABORT <= 1'b0;
            CORE_PADDR       <= 32'h0;
            EXT_REQ          <= 1'b0;
            EXT_ADDR         <= 32'h0;
            EXT_WRITE        <= 1'b0;
            EXT_CACHEABLE    <= 1'b0;
            EXT_BUFFERABLE   <= 1'b0;
        end else begin
            CORE_DONE        <= 1'b0;
            CORE_ABORT       <= 1'b0;
            CORE_FETCH_ABORT <= 1'b0;
            EXT_REQ          <= 1'b0;
            case (state_reg)
                mpw_pkg::ST_IDLE: begin
                    // done blocks a retake while the core drops its request
                    if (CORE_REQ && !CORE_DONE) begin
                        va_reg    <= CORE_VADDR;
                        wr_reg    <= CORE_WRITE;
                        word_reg  <= CORE_WORD;
                        data_reg  <= CORE_DATA;
                        user_reg  <= CORE_USER;
                        state_reg <= mpw_pkg::ST_CHECK;
                    end
                end
                mpw_pkg::ST_CHECK: begin
                    if (fin) begin
                        state_reg <= mpw_pkg::ST_IDLE;
                    end else if (tlb_hit) begin
                        l1_reg    <= hit_l1;
                        l2_reg    <= hit_l2;
                        state_reg <= mpw_pkg::ST_JUDGE;
                    end else begin
                        // miss starts the walk, core stalls
                        MEM_REQ   <= 1'b1;
                        MEM_ADDR  <= l1_addr;
                        state_reg <= mpw_pkg::ST_L1;
                    end
                end
                mpw_pkg::ST_L1: begin
                    if (MEM_ACK) begin
                        l1_reg <= MEM_RDATA;
                        if (fin) begin
                            MEM_REQ   <= 1'b0;
                            state_reg <= mpw_pkg::ST_IDLE;
                        end else if (l1_sect) begin
                            MEM_REQ   <= 1'b0;
                            state_reg <= mpw_pkg::ST_JUDGE;
                        end else begin
                            // page table descriptor leads to second fetch
                            MEM_ADDR  <= l2_addr;
                            state_reg <= mpw_pkg::ST_L2;
                        end
                    end
                end
                mpw_pkg::ST_L2: begin
                    if (MEM_ACK) begin
                        MEM_REQ   <= 1'b0;
                        l2_reg    <= MEM_RDATA;
                        state_reg <= mpw_pkg::ST_JUDGE;
                    end
                end
                mpw_pkg::ST_JUDGE: begin
                    state_reg <= mpw_pkg::ST_IDLE;
                end
                default: state_reg <= mpw_pkg::ST_IDLE;
            endcase
            if (fin) begin
                CORE_DONE <= 1'b1;
                CORE_ABORT       <= fault && data_reg;
                CORE_FETCH_ABORT <= fault && !data_reg;
                CORE_PADDR       <= fin_pa;
                // a faulted access never reaches memory
                EXT_REQ        <= !fault;
                EXT_ADDR       <= fin_pa;
                EXT_WRITE      <= wr_reg;
                EXT_CACHEABLE  <= fin_c;
                EXT_BUFFERABLE <= fin_b;
            end
        end
    end

    // translation buffer fill, flush and purge
    always_ff @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            tlb_vld_reg <= '0;
            tlb_ptr_reg <= 2'h0;
        end else begin
            if (wr_fstat) begin
                tlb_vld_reg <= '0;
            end else if (wr_faddr) begin
                for (int i = 0; i < TLB_N; i++) begin
                    if (tlb_tag[i] == w_data_reg[31:12]) begin
                        tlb_vld_reg[i] <= 1'b0;
                    end
                end
            end
            // fill wins over a same-cycle flush or purge
            if (MEM_ACK && ((state_reg == mpw_pkg::ST_L1 && l1_sect) ||
                            (state_reg == mpw_pkg::ST_L2 && l2_valid))) begin
                tlb_vld_reg[tlb_ptr_reg] <= 1'b1;
                tlb_ptr_reg              <= tlb_ptr_reg + 2'h1;
            end
        end
    end

    // buffer contents carry no reset; the valid bits guard them
    always_ff @(posedge CORE_CLK) begin
        if (MEM_ACK && state_reg == mpw_pkg::ST_L1 && l1_sect) begin
            tlb_tag[tlb_ptr_reg] <= va_reg[31:12];
            tlb_l1[tlb_ptr_reg]  <= MEM_RDATA;
            tlb_l2[tlb_ptr_reg]  <= 32'h0;
        end else if (MEM_ACK && state_reg == mpw_pkg::ST_L2 && l2_valid) begin
            tlb_tag[tlb_ptr_reg] <= va_reg[31:12];
            tlb_l1[tlb_ptr_reg]  <= l1_reg;
            tlb_l2[tlb_ptr_reg]  <= MEM_RDATA;
        end
    end
endmodule

// [tb/mpw_top_properties.sv]
/* checker of core answers and table walk timing
   assumes binding onto the mpw_top ports */
`timescale 1ns/1ps
module mpw_top_properties (input wire logic CORE_CLK, RSTN, CORE_REQ, CORE_DATA, CORE_DONE,
    input wire logic CORE_ABORT, CORE_FETCH_ABORT, MEM_REQ, MEM_ACK, EXT_REQ);
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (!RSTN);
    sequence s_walk_end; MEM_REQ && MEM_ACK ##1 !MEM_REQ; endsequence
    property p_ab; CORE_ABORT |-> CORE_DONE && CORE_DATA && !EXT_REQ; endproperty
    a_ab: assert property (p_ab) else $error("data abort malformed");
    property p_fa; CORE_FETCH_ABORT |-> CORE_DONE && !CORE_DATA && !EXT_REQ; endproperty
    a_fa: assert property (p_fa) else $error("fetch abort malformed");
    property p_ext; EXT_REQ |-> CORE_DONE && !CORE_ABORT && !CORE_FETCH_ABORT; endproperty
    a_ext: assert property (p_ext) else $error("external access on fault");
    property p_one; CORE_DONE |=> !CORE_DONE; endproperty
    a_one: assert property (p_one) else $error("done too long");
    property p_req; CORE_DONE |-> CORE_REQ; endproperty
    a_req: assert property (p_req) else $error("done without request");
    property p_stall; MEM_REQ |-> !CORE_DONE; endproperty
    a_stall: assert property (p_stall) else $error("done during walk");
    property p_hold; MEM_REQ && !MEM_ACK |=> MEM_REQ; endproperty
    a_hold: assert property (p_hold) else $error("table read dropped");
    property p_judge; s_walk_end |-> ##[0:1] CORE_DONE; endproperty
    a_judge: assert property (p_judge) else $error("no answer after walk");
endmodule

// [tb/mpw_mem_model.sv]
/* table memory with adjustable latency
   assumes the bench fills mem before use */
`timescale 1ns/1ps
module mpw_mem_model (
    // table reads
    input  wire logic        clk,
    input  wire logic        req,
    input  wire logic [31:0] addr,
    output logic             ack = 1'b0,
    output logic [31:0]      rdata = 32'h0
);
    logic [31:0] mem [logic [31:0]];
    int          lat = 0;
    int          cnt = 0;
    always @(posedge clk) begin
        ack <= 1'b0;
        rdata <= ~rdata; // released bus never holds
        cnt <= 0;
        if (req && !ack && cnt < lat) cnt <= cnt + 1;
        else if (req && !ack) begin
            ack <= 1'b1;
            rdata <= mem.exists(addr) ? mem[addr] : 32'h0;
        end
    end
endmodule

// [tb/mpw_top_tb.sv]
/* bench: register bus, core accesses, fault status
   assumes mpw_top and the memory model */
`timescale 1ns/1ps
module mpw_top_tb;
    logic CORE_CLK = 0, RSTN = 0, AWVALID = 0, WVALID = 0, BREADY = 0, ARVALID = 0, RREADY = 0;
    logic CORE_REQ = 0, CORE_WRITE = 0, CORE_WORD = 0, CORE_DATA = 0, CORE_USER = 0;
    logic [7:0] AWADDR = '0, ARADDR = '0;
    logic [3:0] WSTRB = 4'hf;
    logic [31:0] WDATA = '0, CORE_VADDR = '0, MEM_RDATA, RDATA, CORE_PADDR, MEM_ADDR, EXT_ADDR, rv;
    logic [1:0] BRESP, RRESP, rr;
    logic AWREADY, WREADY, BVALID, ARREADY, RVALID, CORE_DONE, CORE_ABORT, CORE_FETCH_ABORT;
    logic MEM_REQ, MEM_ACK, EXT_REQ, EXT_WRITE, EXT_CACHEABLE, EXT_BUFFERABLE;
    int num_errors = 0, compares = 0, cyc = 0;
    mpw_top DUT (.CORE_CLK(CORE_CLK), .RSTN(RSTN), .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY),
        .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID),
        .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP),
        .RVALID(RVALID), .RREADY(RREADY), .CORE_REQ(CORE_REQ), .CORE_VADDR(CORE_VADDR), .CORE_WRITE(CORE_WRITE),
        .CORE_WORD(CORE_WORD), .CORE_DATA(CORE_DATA), .CORE_USER(CORE_USER), .CORE_DONE(CORE_DONE),
        .CORE_ABORT(CORE_ABORT), .CORE_FETCH_ABORT(CORE_FETCH_ABORT), .CORE_PADDR(CORE_PADDR), .MEM_REQ(MEM_REQ),
        .MEM_ADDR(MEM_ADDR), .MEM_RDATA(MEM_RDATA), .MEM_ACK(MEM_ACK), .EXT_REQ(EXT_REQ), .EXT_ADDR(EXT_ADDR),
        .EXT_WRITE(EXT_WRITE), .EXT_CACHEABLE(EXT_CACHEABLE), .EXT_BUFFERABLE(EXT_BUFFERABLE));
    mpw_mem_model m (.clk(CORE_CLK), .req(MEM_REQ), .addr(MEM_ADDR), .ack(MEM_ACK), .rdata(MEM_RDATA));
    always #5 CORE_CLK = ~CORE_CLK;
    always @(posedge CORE_CLK) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            num_errors++;
            summarize();
        end
    end
    task summarize();
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task chk(input logic [31:0] s, e);
        compares++;
        if (s !== e) begin
            num_errors++;
            $display("BAD %0t seen %h expected %h", $time, s, e);
        end
    endtask
    function automatic logic [31:0] l1(input logic [31:0] va);
        return {18'h00001, va[31:20], 2'h0};
    endfunction
    task wr(input logic [7:0] a, input logic [31:0] d);
        logic aw, w;
        aw = 0; w = 0;
        @(posedge CORE_CLK);
        AWADDR <= a; WDATA <= d; AWVALID <= 1'b1; WVALID <= 1'b1; BREADY <= 1'b1;
        do begin
            @(posedge CORE_CLK);
            if (AWREADY === 1'b1) begin aw = 1; AWVALID <= 1'b0; end
            if (WREADY === 1'b1) begin w = 1; WVALID <= 1'b0; end
        end while (!(aw && w));
        do @(posedge CORE_CLK); while (BVALID !== 1'b1);
        BREADY <= 1'b0; rr = BRESP;
    endtask
    task rd(input logic [7:0] a);
        @(posedge CORE_CLK);
        ARADDR <= a; ARVALID <= 1'b1; RREADY <= 1'b1;
        do @(posedge CORE_CLK); while (ARREADY !== 1'b1);
        ARVALID <= 1'b0;
        do @(posedge CORE_CLK); while (RVALID !== 1'b1);
        RREADY <= 1'b0; rv = RDATA; rr = RRESP;
    endtask
    // mode bits: user, data, word
    task acc(input logic [31:0] va, input logic [2:0] md, input logic [1:0] ea, input logic [31:0] x);
        @(posedge CORE_CLK);
        {CORE_USER, CORE_DATA, CORE_WORD} <= md; CORE_VADDR <= va; CORE_REQ <= 1'b1;
        do @(posedge CORE_CLK); while (CORE_DONE !== 1'b1);
        CORE_REQ <= 1'b0;
        chk({CORE_ABORT, CORE_FETCH_ABORT}, ea);
        chk(EXT_REQ, ea == 2'b00);
        if (ea == 2'b00) begin
            chk(CORE_PADDR, x);
            chk(EXT_ADDR, x);
            chk(EXT_WRITE, CORE_WRITE);
        end else begin
            rd(8'h0c);
            chk(rv[7:0], x);
        end
    endtask
    initial begin
        m.mem[l1(32'h00200000)] = 32'h000000a0;
        m.mem[l1(32'h00300000)] = 32'h00000c52;
        m.mem[l1(32'h00400000)] = 32'h00000412;
        m.mem[l1(32'h00500000)] = 32'h7ff0003a;
        m.mem[l1(32'h00600000)] = 32'h00010011;
        m.mem[32'h00010000] = 32'h12345d52;
        m.mem[32'h00010008] = 32'h00000000;
        repeat (12) @(posedge CORE_CLK);
        RSTN <= 1'b1;
        repeat (4) @(posedge CORE_CLK);
        rd(8'h08); chk(rv, 32'h0);
        rd(8'h20); chk(rv, 32'h0); chk(rr, 2'b10);
        wr(8'h20, 32'h1); chk(rr, 2'b10);
        wr(8'h08, 32'h0000000d); rd(8'h08); chk(rv, 32'h0000000d);
        wr(8'h00, 32'h2);
        acc(32'h00100001, 3'b011, 2'b10, 32'h01);
        rd(8'h10); chk(rv, 32'h00100001);
        acc(32'h12345679, 3'b010, 2'b00, 32'h12345679);
        wr(8'h04, 32'h00004000); wr(8'h00, 32'h7);
        acc(32'h00200000, 3'b011, 2'b10, 32'h55);
        acc(32'h00300000, 3'b011, 2'b10, 32'h29);
        acc(32'h00400000, 3'b111, 2'b10, 32'h0d);
        acc(32'h00512344, 3'b011, 2'b00, 32'h7ff12344);
        chk({EXT_CACHEABLE, EXT_BUFFERABLE}, 2'b10);
        m.lat = 2;
        acc(32'h00600c10, 3'b110, 2'b00, 32'h12345c10);
        acc(32'h00600010, 3'b110, 2'b10, 32'h0f);
        acc(32'h00602000, 3'b110, 2'b10, 32'h07);
        acc(32'h00400000, 3'b100, 2'b01, 32'h07);
        for (int i = 0; i < 16; i++) m.mem[32'h00011000 + 4 * i] = 32'h87650c05;
        m.mem[l1(32'h00700000)] = 32'h00011011;
        acc(32'h0070c123, 3'b110, 2'b00, 32'h8765c123);
        chk({EXT_CACHEABLE, EXT_BUFFERABLE}, 2'b00);
        acc(32'h00704000, 3'b110, 2'b10, 32'h0f);
        CORE_WRITE <= 1'b1;
        acc(32'h00512344, 3'b011, 2'b00, 32'h7ff12344);
        wr(8'h0c, 32'h0);
        m.mem[l1(32'h00500000)] = 32'h7ff00000;
        acc(32'h00512344, 3'b011, 2'b10, 32'h05);
        summarize();
    end
endmodule
bind mpw_top mpw_top_properties chk_i (.CORE_CLK(CORE_CLK), .RSTN(RSTN), .CORE_REQ(CORE_REQ), .CORE_DATA(CORE_DATA),
    .CORE_DONE(CORE_DONE), .CORE_ABORT(CORE_ABORT), .CORE_FETCH_ABORT(CORE_FETCH_ABORT), .MEM_REQ(MEM_REQ),
    .MEM_ACK(MEM_ACK), .EXT_REQ(EXT_REQ));
